// File: verilog/usb_ep_ctrl_pkg.sv
// Package: register map, reset values and response codes of the endpoint control block
package usb_ep_ctrl_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_DESC_ADDR_HIGH  = 10'h0120;
  localparam logic [9:0] IDX_DESC_ADDR_LOW   = 10'h0121;
  localparam logic [9:0] IDX_DESC_COUNT_HIGH = 10'h0122;
  localparam logic [9:0] IDX_DESC_COUNT_LOW  = 10'h0123;
  localparam logic [9:0] IDX_DMA_FIFO_CTRL   = 10'h0126;
  localparam logic [9:0] IDX_IN_EN_HIGH      = 10'h0128;
  localparam logic [9:0] IDX_IN_EN_LOW       = 10'h0129;
  localparam logic [9:0] IDX_OUT_EN_HIGH     = 10'h012A;
  localparam logic [9:0] IDX_OUT_EN_LOW      = 10'h012B;
  localparam logic [9:0] IDX_IN_ISO_HIGH     = 10'h012C;
  localparam logic [9:0] IDX_IN_ISO_LOW      = 10'h012D;
  localparam logic [9:0] IDX_OUT_ISO_HIGH    = 10'h012E;
  localparam logic [9:0] IDX_OUT_ISO_LOW     = 10'h012F;

  // ==========================================================================
  // Field layout
  localparam int DESC_ADDR_W       = 13;
  localparam int DESC_COUNT_W      = 10;
  localparam int BIT_FIFO_RUNNING  = 7;
  localparam int BIT_AUTO_SHORT    = 6;
  localparam int NUM_EP            = 15;

  // ==========================================================================
  // Reset values
  localparam logic [12:0] RST_DESC_ADDR  = 13'h0000;
  localparam logic [9:0]  RST_DESC_COUNT = 10'h0000;
  localparam logic [15:1] RST_EP_ENABLE  = 15'h0000;
  localparam logic [7:0]  RST_BYTE       = 8'h00;

  // ==========================================================================
  // Token kinds and answers
  typedef enum logic [1:0] {TOK_IN, TOK_OUT, TOK_PING, TOK_OTHER} token_kind_t;
  typedef enum logic [1:0] {RESP_NORMAL, RESP_NAK, RESP_ZERO_LEN, RESP_SILENT} resp_kind_t;

endpackage

// File: verilog/token_resp_if.sv
// Interface: token decision signals between the control block and the responder
`timescale 1ns/1ns
interface token_resp_if;
  import usb_ep_ctrl_pkg::*;
  logic        tokenValid;
  token_kind_t tokenKind;
  logic [3:0]  tokenEp;
  logic        hsMode;
  logic [15:1] inEnable;
  logic [15:1] outEnable;
  logic [15:1] inIso;
  logic [15:1] outIso;
  logic [15:1] joined;
  logic        respValid;
  resp_kind_t  respKind;

  modport ctrl (output tokenValid, tokenKind, tokenEp, hsMode, inEnable, outEnable,
                output inIso, outIso, joined, input respValid, respKind);
  modport responder (input tokenValid, tokenKind, tokenEp, hsMode, inEnable, outEnable,
                     input inIso, outIso, joined, output respValid, respKind);
endinterface

// File: verilog/token_responder.sv
// Responder: answers every token; special answers only for enabled endpoints that have no FIFO area joined
`timescale 1ns/1ns
module token_responder
  import usb_ep_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  token_resp_if.responder  tok
);

  typedef struct packed {
    logic       respValid;
    resp_kind_t respKind;
  } state_t;

  state_t stateReg;
  state_t stateNext;

  // ==========================================================================
  // Decision
  always_comb begin
    logic epIn;
    logic epOut;
    logic unjoined;
    epIn      = 1'b0;
    epOut     = 1'b0;
    unjoined  = 1'b0;
    stateNext = stateReg;
    stateNext.respValid = tok.tokenValid;
    stateNext.respKind  = RESP_NORMAL;
    if (tok.tokenEp != 4'h0) begin
      epIn     = tok.inEnable[tok.tokenEp];
      epOut    = tok.outEnable[tok.tokenEp];
      unjoined = !tok.joined[tok.tokenEp];
    end
    if (tok.tokenValid && unjoined) begin
      case (tok.tokenKind)
        TOK_IN: begin
          if (epIn) begin
            stateNext.respKind = tok.inIso[tok.tokenEp] ? RESP_ZERO_LEN
                                                        : RESP_NAK;
          end
        end
        TOK_OUT: begin
          if (epOut) begin
            stateNext.respKind = tok.outIso[tok.tokenEp] ? RESP_SILENT
                                                         : RESP_NAK;
          end
        end
        TOK_PING: begin
          if (epOut && tok.hsMode) begin
            stateNext.respKind = RESP_NAK;
          end
        end
        default: begin
          stateNext.respKind = RESP_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg <= '{respValid: 1'b0, respKind: RESP_NORMAL};
    end else begin
      stateReg <= stateNext;
    end
  end

  assign tok.respValid = stateReg.respValid;
  assign tok.respKind  = stateReg.respKind;

endmodule // token_responder

// File: verilog/usb_device_endpoint_enable_ctrl.sv
// Device endpoint control: descriptor counter, DMA FIFO status and endpoint enables
//
// Notes on behaviour
// - Descriptor byte count is 10 bits over two registers, any value accepted.
// - Each finished EP0 IN during reply lowers the count by bytes sent, down to zero.
// - FIFO-running sets on DMA start, clears when FIFO empties after DMA done.
// - Auto arm sets short-packet enable on odd leftover below max packet.
// - Auto arm also acts when the DMA endpoint is an IN endpoint.
// - IN enable bits for endpoints 1..15; low bit 0 reserved; 1 enables.
// - OUT enable bits use the same layout and encoding.
// - Special answers only for enabled endpoints without a joined FIFO area.
// - IN to such iso endpoint gets a zero-length packet.
// - IN to such non-iso endpoint gets NAK.
// - OUT to such iso endpoint: data dropped, no handshake.
// - OUT to such non-iso endpoint gets NAK.
// - PING at high speed to such endpoint gets NAK.
// - Descriptor start address is 13 bits, advanced by bytes sent per EP0 IN during reply.
`timescale 1ns/1ns
module usb_device_endpoint_enable_ctrl
  import usb_ep_ctrl_pkg::*;
#(
  parameter int ADDR_W  = 12,
  parameter int FIFO_W  = 13,
  parameter int PKT_W   = 11
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]       address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  input  wire logic [3:0]              byteenable,
  output logic      [31:0]             readdata,
  output logic                         waitrequest,
  // Descriptor reply progress
  input  wire logic                    descReplyActive,
  input  wire logic                    ep0InDone,
  input  wire logic [9:0]              ep0InBytes,
  // DMA and FIFO status
  input  wire logic                    dmaStart,
  input  wire logic                    dmaDone,
  input  wire logic                    fifoEmpty,
  input  wire logic [FIFO_W-1:0]       fifoRemain,
  input  wire logic [PKT_W-1:0]        maxPacketSize,
  input  wire logic [3:0]              dmaEndpoint,
  output logic                         shortPacketSet,
  output logic      [3:0]              shortPacketEp,
  // Token path
  input  wire logic                    hsMode,
  input  wire logic [15:1]             endpointJoined,
  input  wire logic                    tokenValid,
  input  wire token_kind_t             tokenKind,
  input  wire logic [3:0]              tokenEp,
  output logic                         respValid,
  output resp_kind_t                   respKind,
  // State views
  output logic [DESC_ADDR_W-1:0]       descStartAddress,
  output logic [DESC_COUNT_W-1:0]      descByteCount,
  output logic [15:1]                  inEnable,
  output logic [15:1]                  outEnable
);

  typedef struct packed {
    logic                    ack;
    logic [7:0]              readByte;
    logic [DESC_ADDR_W-1:0]  descAddr;
    logic [DESC_COUNT_W-1:0] descCount;
    logic [7:0]              countLowShadow;
    logic                    shadowValid;
    logic                    fifoRunning;
    logic                    dmaFinished;
    logic                    autoShort;
    logic                    shortSet;
    logic [3:0]              shortEp;
    logic [15:1]             inEn;
    logic [15:1]             outEn;
    logic [15:1]             inIso;
    logic [15:1]             outIso;
  } state_t;

  state_t stateReg;
  state_t stateNext;

  logic       request;
  logic       aligned;
  logic [9:0] regIndex;
  logic       wrAccept;
  logic [7:0] wrByte;

  token_resp_if tok ();

  // ==========================================================================
  // Bus decode
  assign request     = read | write;
  assign aligned     = (address[1:0] == 2'b00);
  assign regIndex    = aligned ? 10'(address[ADDR_W-1:2]) : 10'h0000;
  assign waitrequest = request & ~stateReg.ack;
  assign wrAccept    = write & stateReg.ack & byteenable[0];
  assign wrByte      = writedata[7:0];

  // ==========================================================================
  // Read value of one register
  function automatic logic [7:0] read_value(input state_t s, input logic [9:0] idx);
    logic [7:0] v;
    v = RST_BYTE;
    case (idx)
      IDX_DESC_ADDR_HIGH:  v = {3'b000, s.descAddr[12:8]};
      IDX_DESC_ADDR_LOW:   v = s.descAddr[7:0];
      IDX_DESC_COUNT_HIGH: v = {6'b00_0000, s.descCount[9:8]};
      IDX_DESC_COUNT_LOW:  v = s.shadowValid ? s.countLowShadow : s.descCount[7:0];
      IDX_DMA_FIFO_CTRL:   v = {s.fifoRunning, s.autoShort, 6'b00_0000};
      IDX_IN_EN_HIGH:      v = s.inEn[15:8];
      IDX_IN_EN_LOW:       v = {s.inEn[7:1], 1'b0};
      IDX_OUT_EN_HIGH:     v = s.outEn[15:8];
      IDX_OUT_EN_LOW:      v = {s.outEn[7:1], 1'b0};
      IDX_IN_ISO_HIGH:     v = s.inIso[15:8];
      IDX_IN_ISO_LOW:      v = {s.inIso[7:1], 1'b0};
      IDX_OUT_ISO_HIGH:    v = s.outIso[15:8];
      IDX_OUT_ISO_LOW:     v = {s.outIso[7:1], 1'b0};
      default:             v = RST_BYTE;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    stateNext = stateReg;
    stateNext.ack      = request & ~stateReg.ack;
    stateNext.shortSet = 1'b0;

    // Read data prepared one cycle ahead of the accepting edge
    if (read && !stateReg.ack) begin
      stateNext.readByte = read_value(stateReg, regIndex);
      if (regIndex == IDX_DESC_COUNT_HIGH) begin
        stateNext.countLowShadow = stateReg.descCount[7:0];
        stateNext.shadowValid    = 1'b1;
      end
    end
    if (read && stateReg.ack && regIndex == IDX_DESC_COUNT_LOW) begin
      stateNext.shadowValid = 1'b0;
    end

    // Register writes
    if (wrAccept) begin
      case (regIndex)
        IDX_DESC_ADDR_HIGH:  stateNext.descAddr[12:8] = wrByte[4:0];
        IDX_DESC_ADDR_LOW:   stateNext.descAddr[7:0]  = wrByte;
        IDX_DESC_COUNT_HIGH: stateNext.descCount[9:8] = wrByte[1:0];
        IDX_DESC_COUNT_LOW:  stateNext.descCount[7:0] = wrByte;
        IDX_DMA_FIFO_CTRL:   stateNext.autoShort = wrByte[BIT_AUTO_SHORT];
        IDX_IN_EN_HIGH:      stateNext.inEn[15:8]  = wrByte;
        IDX_IN_EN_LOW:       stateNext.inEn[7:1]   = wrByte[7:1];
        IDX_OUT_EN_HIGH:     stateNext.outEn[15:8] = wrByte;
        IDX_OUT_EN_LOW:      stateNext.outEn[7:1]  = wrByte[7:1];
        IDX_IN_ISO_HIGH:     stateNext.inIso[15:8]  = wrByte;
        IDX_IN_ISO_LOW:      stateNext.inIso[7:1]   = wrByte[7:1];
        IDX_OUT_ISO_HIGH:    stateNext.outIso[15:8] = wrByte;
        IDX_OUT_ISO_LOW:     stateNext.outIso[7:1]  = wrByte[7:1];
        default:             stateNext.inEn = stateNext.inEn;
      endcase
    end

    // Descriptor reply progress; hardware update wins over a same-cycle write
    if (descReplyActive && ep0InDone) begin
      stateNext.descAddr = DESC_ADDR_W'(stateReg.descAddr + {3'b000, ep0InBytes});
      if (stateReg.descCount > ep0InBytes) begin
        stateNext.descCount = stateReg.descCount - ep0InBytes;
      end else begin
        stateNext.descCount = RST_DESC_COUNT;
      end
    end

    // FIFO running flag; a start wins over the emptied clear, a same-cycle completion only sets dmaFinished again
    if (stateReg.fifoRunning && stateReg.dmaFinished && fifoEmpty) begin
      stateNext.fifoRunning = 1'b0;
      stateNext.dmaFinished = 1'b0;
    end
    if (dmaDone) begin
      stateNext.dmaFinished = 1'b1;
    end
    if (dmaStart) begin
      stateNext.fifoRunning = 1'b1;
      stateNext.dmaFinished = 1'b0;
    end

    // Automatic short packet arming, direction not considered
    if (dmaDone && stateReg.autoShort && fifoRemain[0]
        && (FIFO_W'(maxPacketSize) > fifoRemain)) begin
      stateNext.shortSet = 1'b1;
      stateNext.shortEp  = dmaEndpoint;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg.ack            <= 1'b0;
      stateReg.readByte       <= RST_BYTE;
      stateReg.descAddr       <= RST_DESC_ADDR;
      stateReg.descCount      <= RST_DESC_COUNT;
      stateReg.countLowShadow <= RST_BYTE;
      stateReg.shadowValid    <= 1'b0;
      stateReg.fifoRunning    <= 1'b0;
      stateReg.dmaFinished    <= 1'b0;
      stateReg.autoShort      <= 1'b0;
      stateReg.shortSet       <= 1'b0;
      stateReg.shortEp        <= 4'h0;
      stateReg.inEn           <= RST_EP_ENABLE;
      stateReg.outEn          <= RST_EP_ENABLE;
      stateReg.inIso          <= RST_EP_ENABLE;
      stateReg.outIso         <= RST_EP_ENABLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ==========================================================================
  // Token responder
  assign tok.tokenValid = tokenValid;
  assign tok.tokenKind  = tokenKind;
  assign tok.tokenEp    = tokenEp;
  assign tok.hsMode     = hsMode;
  assign tok.inEnable   = stateReg.inEn;
  assign tok.outEnable  = stateReg.outEn;
  assign tok.inIso      = stateReg.inIso;
  assign tok.outIso     = stateReg.outIso;
  assign tok.joined     = endpointJoined;

  token_responder u_responder (
    .clk  (clk),
    .srst (srst),
    .tok  (tok.responder)
  );

  // ==========================================================================
  // Outputs
  assign readdata         = {24'h00_0000, stateReg.readByte};
  assign respValid        = tok.respValid;
  assign respKind         = tok.respKind;
  assign shortPacketSet   = stateReg.shortSet;
  assign shortPacketEp    = stateReg.shortEp;
  assign descStartAddress = stateReg.descAddr;
  assign descByteCount    = stateReg.descCount;
  assign inEnable         = stateReg.inEn;
  assign outEnable        = stateReg.outEn;

endmodule // usb_device_endpoint_enable_ctrl

// File: tb/usb_ep_ctrl_checker.sv
// Checker: port properties of the endpoint control block
`timescale 1ns/1ns
module usb_ep_ctrl_checker
  import usb_ep_ctrl_pkg::*;
#(parameter int ADDR_W = 12, parameter int FIFO_W = 13, parameter int PKT_W = 11) (
  input wire logic clk, srst, read, write, waitrequest, descReplyActive, ep0InDone,
  input wire logic dmaStart, dmaDone, fifoEmpty, shortPacketSet, hsMode, tokenValid, respValid,
  input wire logic [ADDR_W-1:0]      address,
  input wire logic [31:0]            writedata, readdata,
  input wire logic [3:0]             byteenable, dmaEndpoint, shortPacketEp, tokenEp,
  input wire logic [9:0]             ep0InBytes,
  input wire logic [DESC_COUNT_W-1:0] descByteCount,
  input wire logic [FIFO_W-1:0]      fifoRemain,
  input wire logic [PKT_W-1:0]       maxPacketSize,
  input wire logic [DESC_ADDR_W-1:0] descStartAddress,
  input wire logic [15:1]            endpointJoined, inEnable, outEnable,
  input wire token_kind_t            tokenKind,
  input wire resp_kind_t             respKind
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic inHit, outHit, dn;
  assign inHit  = tokenEp != 4'h0 && inEnable[tokenEp] && !endpointJoined[tokenEp];
  assign outHit = tokenEp != 4'h0 && outEnable[tokenEp] && !endpointJoined[tokenEp];
  assign dn     = ep0InDone && descReplyActive;
  property p_answer; tokenValid |=> respValid; endproperty
  a_answer: assert property (p_answer) else $error("token not answered");
  property p_quiet; !tokenValid |=> !respValid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without token");
  property p_joined; tokenValid && tokenEp != 4'h0 && endpointJoined[tokenEp]
    |=> respKind == RESP_NORMAL; endproperty
  a_joined: assert property (p_joined) else $error("joined endpoint not normal");
  property p_in; tokenValid && tokenKind == TOK_IN && inHit
    |=> respKind inside {RESP_NAK, RESP_ZERO_LEN}; endproperty
  a_in: assert property (p_in) else $error("bad IN answer");
  property p_out; tokenValid && tokenKind == TOK_OUT && outHit
    |=> respKind inside {RESP_NAK, RESP_SILENT}; endproperty
  a_out: assert property (p_out) else $error("bad OUT answer");
  property p_ping; tokenValid && tokenKind == TOK_PING && hsMode && outHit
    |=> respKind == RESP_NAK; endproperty
  a_ping: assert property (p_ping) else $error("bad PING answer");
  property p_count; dn |=> descByteCount == (($past(descByteCount) > $past(ep0InBytes))
    ? $past(descByteCount) - $past(ep0InBytes) : 10'h000); endproperty
  a_count: assert property (p_count) else $error("count not lowered");
  property p_addr; dn |=> descStartAddress == 13'($past(descStartAddress) + $past(ep0InBytes));
  endproperty
  a_addr: assert property (p_addr) else $error("address not advanced");
  property p_short; shortPacketSet |-> $past(dmaDone) && $past(fifoRemain[0])
    && $past(fifoRemain) < $past(maxPacketSize) && shortPacketEp == $past(dmaEndpoint); endproperty
  a_short: assert property (p_short) else $error("bad short arm");
  property p_upper; read && !waitrequest |-> readdata[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_reset; disable iff (1'b0) srst |=> descByteCount == 10'h000
    && inEnable == 15'h0000 && outEnable == 15'h0000 && !respValid; endproperty
  a_reset: assert property (p_reset) else $error("state not cleared");
  c_ping: cover property (tokenValid && tokenKind == TOK_PING && hsMode && outHit);
  c_short: cover property (shortPacketSet);
  c_desc: cover property (dn);
endmodule // usb_ep_ctrl_checker
bind usb_device_endpoint_enable_ctrl usb_ep_ctrl_checker
  #(.ADDR_W(ADDR_W), .FIFO_W(FIFO_W), .PKT_W(PKT_W)) i_usb_ep_ctrl_checker (.*);

// File: tb/usb_host_token_model.sv
// Host model: issues tokens and takes the one-cycle answer
`timescale 1ns/1ns
module usb_host_token_model
  import usb_ep_ctrl_pkg::*;
(
  input  wire logic       clk,
  output logic            tokenValid,
  output token_kind_t     tokenKind,
  output logic [3:0]      tokenEp,
  input  wire logic       respValid,
  input  wire resp_kind_t respKind
);
  initial begin
    tokenValid = 1'b0;
    tokenKind  = TOK_OTHER;
    tokenEp    = 4'h0;
  end
  task automatic issue(input token_kind_t k, input logic [3:0] e,
                       output logic v, output resp_kind_t r);
    @(posedge clk);
    tokenValid <= 1'b1;
    tokenKind  <= k;
    tokenEp    <= e;
    @(posedge clk);
    tokenValid <= 1'b0;
    tokenKind  <= TOK_OTHER;
    tokenEp    <= ~e;
    @(posedge clk);
    v = respValid;
    r = respKind;
  endtask
endmodule // usb_host_token_model

// File: tb/tb_usb_device_endpoint_enable_ctrl.sv
// Testbench: registers, descriptor count, DMA status and token answers
`timescale 1ns/1ns
module tb_usb_device_endpoint_enable_ctrl;
  import usb_ep_ctrl_pkg::*;
  logic clk, srst, read, write, waitrequest, descReplyActive, ep0InDone, dmaStart, dmaDone;
  logic fifoEmpty, shortPacketSet, hsMode, tokenValid, respValid, mRun;
  logic [11:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable, dmaEndpoint, shortPacketEp, tokenEp;
  logic [9:0]  ep0InBytes, descByteCount;
  logic [12:0] fifoRemain, descStartAddress;
  logic [10:0] maxPacketSize;
  logic [15:1] endpointJoined, inEnable, outEnable;
  token_kind_t tokenKind;
  resp_kind_t  respKind;
  logic [7:0]  mReg [16];
  logic [3:0]  mEp = 4'h0;
  int          errTotal = 0, checked = 0, cyc = 0;
  localparam logic [7:0] WMASK [16] = '{8'h1F, 8'hFF, 8'h03, 8'hFF, 8'h00, 8'h00, 8'h40, 8'h00,
                                       8'hFF, 8'hFE, 8'hFF, 8'hFE, 8'hFF, 8'hFE, 8'hFF, 8'hFE};
  localparam logic [12:0] REM [5] = '{13'h0003, 13'h0004, 13'h003F, 13'h0041, 13'h0003};
  usb_device_endpoint_enable_ctrl i_usb_device_endpoint_enable_ctrl (.*);
  usb_host_token_model i_usb_host_token_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errTotal++;
      finish_test();
    end
  end
  // ==========================================================================
  // Checks and bus
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmpResp(input resp_kind_t e, input resp_kind_t g);
    checked++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH respKind exp %s got %s", e.name(), g.name());
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] q);
    @(posedge clk);
    read       <= !w;
    write      <= w;
    address    <= {idx, 2'b00};
    writedata  <= {24'($urandom), d};
    byteenable <= be;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, 4'h1, q);
    mReg[idx[3:0]] = d & WMASK[idx[3:0]];
  endtask
  function automatic logic [7:0] expRd(input int i);
    return (i == 6) ? {mRun, mReg[6][6:0]} : mReg[i];
  endfunction
  task automatic chkAll();
    logic [7:0] q;
    for (int i = 0; i < 17; i++) begin
      bus(1'b0, IDX_DESC_ADDR_HIGH + 10'(i), 8'h00, 4'h1, q);
      cmp("register", (i < 16) ? 16'(expRd(i)) : 16'h0000, 16'(q));
    end
    cmp("inEnable", {mReg[8], mReg[9][7:1]}, 16'(inEnable));
    cmp("outEnable", {mReg[10], mReg[11][7:1]}, 16'(outEnable));
    cmp("count", {mReg[2], mReg[3]}, 16'(descByteCount));
    cmp("address", {mReg[0], mReg[1]}, 16'(descStartAddress));
  endtask
  task automatic randRegs();
    logic [7:0] d, q;
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      bus(1'b1, IDX_DESC_ADDR_HIGH + 10'(i), ~d, 4'hE, q);
      wr(IDX_DESC_ADDR_HIGH + 10'(i), d);
    end
  endtask
  task automatic epDone(input logic act, input logic [9:0] b);
    logic [15:0] n, a;
    @(posedge clk);
    descReplyActive <= act;
    ep0InDone       <= 1'b1;
    ep0InBytes      <= b;
    @(posedge clk);
    ep0InDone       <= 1'b0;
    descReplyActive <= 1'b0;
    ep0InBytes      <= ~b;
    if (act) begin
      n = {mReg[2], mReg[3]};
      a = {mReg[0], mReg[1]} + 16'(b);
      {mReg[2], mReg[3]} = (n > 16'(b)) ? n - 16'(b) : 16'h0000;
      {mReg[0], mReg[1]} = {3'b000, a[12:0]};
    end
  endtask
  task automatic dma(input logic au, input logic [12:0] rem);
    logic [7:0] q;
    logic       s;
    wr(IDX_DMA_FIFO_CTRL, {1'b0, au, 6'h00});
    @(posedge clk);
    dmaStart    <= 1'b1;
    fifoEmpty   <= 1'b0;
    fifoRemain  <= rem;
    dmaEndpoint <= 4'($urandom);
    @(posedge clk);
    dmaStart <= 1'b0;
    mRun = 1'b1;
    bus(1'b0, IDX_DMA_FIFO_CTRL, 8'h00, 4'h1, q);
    cmp("running", 16'(expRd(6)), 16'(q));
    @(posedge clk);
    dmaDone <= 1'b1;
    @(posedge clk);
    dmaDone <= 1'b0;
    @(posedge clk);
    s = au && rem[0] && (rem < 13'(maxPacketSize));
    if (s) mEp = dmaEndpoint;
    cmp("shortSet", 16'(s), 16'(shortPacketSet));
    cmp("shortEp", 16'(mEp), 16'(shortPacketEp));
    fifoEmpty <= 1'b1;
    mRun = 1'b0;
    bus(1'b0, IDX_DMA_FIFO_CTRL, 8'h00, 4'h1, q);
    cmp("stopped", 16'(expRd(6)), 16'(q));
  endtask
  function automatic resp_kind_t expResp(input token_kind_t k, input logic [3:0] e);
    logic [15:0] jn, ie, oe, ii, oi;
    jn = {endpointJoined, 1'b0};
    ie = {mReg[8], mReg[9]};
    oe = {mReg[10], mReg[11]};
    ii = {mReg[12], mReg[13]};
    oi = {mReg[14], mReg[15]};
    if (!jn[e]) begin
      if (k == TOK_IN && ie[e]) return ii[e] ? RESP_ZERO_LEN : RESP_NAK;
      if (k == TOK_OUT && oe[e]) return oi[e] ? RESP_SILENT : RESP_NAK;
      if (k == TOK_PING && hsMode && oe[e]) return RESP_NAK;
    end
    return RESP_NORMAL;
  endfunction
  task automatic tokens(input int num);
    logic [3:0] e;
    logic v;
    resp_kind_t r;
    token_kind_t k;
    for (int i = 0; i < num; i++) begin
      k = token_kind_t'(2'(i));
      e = 4'($urandom);
      @(posedge clk);
      hsMode         <= 1'($urandom);
      endpointJoined <= 15'($urandom & $urandom);
      i_usb_host_token_model.issue(k, e, v, r);
      cmp("respValid", 16'h0001, 16'(v));
      cmpResp(expResp(k, e), r);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] q;
    void'($urandom(32'ha908));
    {srst, mRun, fifoEmpty} = 3'b101;
    {read, write, descReplyActive, ep0InDone, dmaStart, dmaDone, hsMode} = 7'h00;
    {address, writedata, byteenable, ep0InBytes, fifoRemain, dmaEndpoint} = '0;
    endpointJoined = 15'h0000;
    maxPacketSize  = 11'h040;
    foreach (mReg[i]) mReg[i] = 8'h00;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    chkAll();
    $display("test reset done");
    repeat (2) begin
      randRegs();
      chkAll();
      tokens(32);
    end
    $display("test registers and tokens done");
    wr(IDX_DESC_COUNT_HIGH, 8'h03);
    wr(IDX_DESC_COUNT_LOW, 8'hFF);
    wr(IDX_DESC_ADDR_HIGH, 8'h11);
    wr(IDX_DESC_ADDR_LOW, 8'hFF);
    for (int i = 0; i < 8; i++) epDone(i != 3, 10'($urandom % 300) + 10'h001);
    epDone(1'b1, 10'h3FF);
    chkAll();
    wr(IDX_DESC_COUNT_HIGH, 8'h01);
    wr(IDX_DESC_COUNT_LOW, 8'h00);
    bus(1'b0, IDX_DESC_COUNT_HIGH, 8'h00, 4'h1, q);
    cmp("countHigh", 16'h0001, 16'(q));
    epDone(1'b1, 10'h001);
    bus(1'b0, IDX_DESC_COUNT_LOW, 8'h00, 4'h1, q);
    cmp("countLowHeld", 16'h0000, 16'(q));
    bus(1'b0, IDX_DESC_COUNT_LOW, 8'h00, 4'h1, q);
    cmp("countLowLive", 16'h00FF, 16'(q));
    $display("test descriptor done");
    for (int k = 0; k < 5; k++) dma(k != 4, REM[k]);
    $display("test dma done");
    finish_test();
  end
endmodule // tb_usb_device_endpoint_enable_ctrl
